// file: hw/fcp_defines.svh
// named offsets, bit positions, command codes and reset values
// assumes inclusion by bare name from the package and the design module
`ifndef FCP_DEFINES_SVH
`define FCP_DEFINES_SVH

// ****************************************************************
// register offsets on the plain register port
// ****************************************************************
`define FCP_OFS_DIV      3'h0
`define FCP_OFS_PROT     3'h1
`define FCP_OFS_STAT     3'h2
`define FCP_OFS_CMD      3'h3
`define FCP_OFS_IRQ_STAT 3'h4
`define FCP_OFS_IRQ_MASK 3'h5

// ****************************************************************
// flash_status_reg fields
// ****************************************************************
`define FCP_ST_CBEF  7
`define FCP_ST_BUSY  6
`define FCP_ST_PVIOL 5
`define FCP_ST_ACCER 4

// ****************************************************************
// irq status / mask fields
// ****************************************************************
`define FCP_IRQ_ACCER 0
`define FCP_IRQ_PVIOL 1
`define FCP_IRQ_DONE  2

// ****************************************************************
// command codes
// ****************************************************************
`define FCP_CMD_BLANK 8'h05
`define FCP_CMD_BYTE  8'h20
`define FCP_CMD_BURST 8'h25
`define FCP_CMD_PAGE  8'h40
`define FCP_CMD_MASS  8'h41

// ****************************************************************
// protection and reset values
// ****************************************************************
`define FCP_PROT_DIS_BIT 0
`define FCP_PAGE_ONES    9'h1ff
`define FCP_PROT_RST     8'hff
`define FCP_BYTE_ZERO    8'h00
`define FCP_ADDR_ZERO    16'h0000
`define FCP_IRQ_ZERO     3'h0

`endif

// file: hw/fcp_pkg.sv
// types shared by the flash command guard
// assumes fcp_defines.svh is on the include path
package fcp_pkg;
  `include "fcp_defines.svh"

  // ****************************************************************
  // command sequence states
  // ****************************************************************
  typedef enum logic [1:0] {
    SEQ_IDLE,      // waiting for the array address write
    SEQ_ADDR,      // address taken, waiting for the command code
    SEQ_CMD        // code taken, waiting for the launch write
  } fcp_seq_t;

  // one register port access, carried as a group
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic       dbg;
  } fcp_req_t;

  // command handed to the flash array
  typedef struct packed {
    logic [7:0]  code;
    logic [15:0] addr;
  } fcp_cmd_t;
endpackage

// file: hw/fcp_flash_guard.sv
// flash command protocol checker and block protection
// assumes one 250 MHz clock, inputs synchronous, RST async active high
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ps
`include "fcp_defines.svh"

// How it works
// - violation sets sticky error; write one clears
// - array write before divider write is error
// - array write while buffer not empty errors
// - second array write per command errors
// - second command code write errors
// - control write after address, except command, errors
// - only five command codes are legal
// - after code, only launching status write among control accesses
// - status write clearing buffer flag launches
// - stop during program or erase aborts, errors
// - secured debug may not program or page-erase
// - writing zero to buffer flag mid-sequence errors
// - protected region refuses program and erase
// - region runs from 512-byte boundary to top
// - protection loaded from nonvolatile byte after reset
// - only debug accesses may write protection
// - select bits plus ones form last free address
module fcp_flash_guard
  import fcp_pkg::*;
#(
  parameter int CMD_CYCLES = 16   // cycles a launched command stays busy
) (
  input  wire logic        CLOCK,
  input  wire logic        RST,
  input  wire logic [2:0]  ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  input  wire logic        DBG_ACCESS,
  output logic      [7:0]  RDATA,
  input  wire logic        ARRAY_WR,
  input  wire logic [15:0] ARRAY_ADDR,
  input  wire logic        SECURED,
  input  wire logic        STOP_ENTRY,
  input  wire logic [7:0]  NV_PROT_BYTE,
  output logic             FL_START,
  output logic      [7:0]  FL_CMD,
  output logic      [15:0] FL_ADDR,
  output logic             FL_ABORT,
  output logic             ACC_ERR,
  output logic             PROT_VIOL,
  output logic             CBEF,
  output logic             BUSY,
  output logic             IRQ
);

  localparam int CW = $clog2(CMD_CYCLES + 1);   // busy counter width
  localparam logic [CW-1:0] CNT_LOAD = CW'(CMD_CYCLES);
  localparam logic [CW-1:0] CNT_ONE  = CW'(1);
  localparam logic [CW-1:0] CNT_ZERO = '0;

  // ****************************************************************
  // state
  // ****************************************************************
  fcp_req_t       req;            // bundled register access
  fcp_seq_t       state;          // command entry progress
  fcp_seq_t       next_state;     // progress after this cycle
  fcp_cmd_t       pend;           // command being entered
  logic           div_written;    // divider set since reset
  logic [7:0]     prot;           // protection_reg
  logic           prot_loaded;    // nonvolatile byte copied in
  logic [CW-1:0]  cnt;            // busy countdown
  logic [2:0]     irq_stat;       // sticky event bits
  logic [2:0]     irq_mask;       // event enables
  logic           err_event;      // some violation this cycle
  logic           launch;         // valid launch write
  logic           refuse;         // launch hits protected flash
  logic           stop_abort;     // stop while program or erase
  logic           done_event;     // busy countdown expires
  logic           wr_div;
  logic           wr_prot;
  logic           wr_stat;
  logic           wr_cmd;
  logic           ctl_sel;        // address is a flash control reg
  logic           code_legal;
  logic           code_restricted;
  logic [15:0]    last_free;      // last unprotected address
  logic           prot_on;        // protection enabled

  assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD, dbg: DBG_ACCESS};

  // ****************************************************************
  // decode
  // ****************************************************************
  assign ctl_sel = (req.addr == `FCP_OFS_DIV)  || (req.addr == `FCP_OFS_PROT)
                || (req.addr == `FCP_OFS_STAT) || (req.addr == `FCP_OFS_CMD);
  assign wr_div  = req.wr && (req.addr == `FCP_OFS_DIV);
  assign wr_prot = req.wr && (req.addr == `FCP_OFS_PROT);
  assign wr_stat = req.wr && (req.addr == `FCP_OFS_STAT);
  assign wr_cmd  = req.wr && (req.addr == `FCP_OFS_CMD);

  // only five codes are accepted
  assign code_legal = (req.wdata == `FCP_CMD_BLANK)
                   || (req.wdata == `FCP_CMD_BYTE)
                   || (req.wdata == `FCP_CMD_BURST)
                   || (req.wdata == `FCP_CMD_PAGE)
                   || (req.wdata == `FCP_CMD_MASS);
  // codes a secured debug port may not issue
  assign code_restricted = (req.wdata == `FCP_CMD_BYTE)
                        || (req.wdata == `FCP_CMD_BURST)
                        || (req.wdata == `FCP_CMD_PAGE);

  // select bits on top, ones below: a 512-byte granule boundary
  assign last_free = {prot[7:1], `FCP_PAGE_ONES};
  // cleared disable bit turns protection on
  assign prot_on   = !prot[`FCP_PROT_DIS_BIT];

  // ****************************************************************
  // violation and launch detection
  // ****************************************************************
  // a set error flag freezes command entry; further strobes are
  // simply ignored rather than compounded into new errors
  always_comb begin
    err_event  = 1'b0;
    launch     = 1'b0;
    refuse     = 1'b0;
    next_state = state;
    if (stop_abort) begin
      err_event = 1'b1;
    end
    if (!ACC_ERR) begin
      if (ARRAY_WR) begin
        if (!div_written) begin
          err_event = 1'b1;
        end else if (!CBEF) begin
          err_event = 1'b1;
        end else if (state != SEQ_IDLE) begin
          err_event = 1'b1;
        end else begin
          next_state = SEQ_ADDR;
        end
      end
      if (wr_cmd) begin
        if (state != SEQ_ADDR) begin
          err_event = 1'b1;
        end else if (!code_legal) begin
          err_event = 1'b1;
        end else if (req.dbg && SECURED && code_restricted) begin
          err_event = 1'b1;
        end else begin
          next_state = SEQ_CMD;
        end
      end
      // after the address the command register is the only control register that may be written
      if (state == SEQ_ADDR && req.wr && ctl_sel && !wr_cmd) begin
        err_event = 1'b1;
      end
      // after the code the launching status write is the only control register access allowed
      if (state == SEQ_CMD && ((req.rd && ctl_sel)
          || (req.wr && ctl_sel && !wr_stat))) begin
        err_event = 1'b1;
      end
      // zero to the buffer flag mid-sequence is a cancel attempt
      if (wr_stat && !req.wdata[`FCP_ST_CBEF] && state != SEQ_IDLE) begin
        err_event = 1'b1;
      end
      if (wr_stat && req.wdata[`FCP_ST_CBEF] && state == SEQ_CMD) begin
        launch     = 1'b1;
        next_state = SEQ_IDLE;
        // blank check never alters flash, so it is never refused
        if (prot_on && pend.code != `FCP_CMD_BLANK) begin
          refuse = (pend.code == `FCP_CMD_MASS)
                || (pend.addr > last_free);
        end
      end
    end
    if (err_event) begin
      launch     = 1'b0;
      refuse     = 1'b0;
      next_state = SEQ_IDLE;
    end
  end

  // stop is only fatal to commands that change the array
  assign stop_abort = STOP_ENTRY && BUSY && (FL_CMD != `FCP_CMD_BLANK);
  assign done_event = BUSY && (cnt == CNT_ONE) && !stop_abort;

  // ****************************************************************
  // sequence state and pending command
  // ****************************************************************
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      state <= SEQ_IDLE;
      pend  <= '{code: `FCP_BYTE_ZERO, addr: `FCP_ADDR_ZERO};
    end else begin
      state <= next_state;
      if (next_state == SEQ_ADDR && state == SEQ_IDLE) begin
        pend.addr <= ARRAY_ADDR;
      end
      if (next_state == SEQ_CMD && state == SEQ_ADDR) begin
        pend.code <= req.wdata;
      end
    end
  end

  // ****************************************************************
  // divider written flag; the divide value itself lives elsewhere
  // ****************************************************************
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      div_written <= 1'b0;
    end else if (wr_div && !err_event) begin
      div_written <= 1'b1;
    end
  end

  // ****************************************************************
  // protection register: load after reset, debug writes only
  // ****************************************************************
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      prot        <= `FCP_PROT_RST;
      prot_loaded <= 1'b0;
    end else if (!prot_loaded) begin
      prot        <= NV_PROT_BYTE;
      prot_loaded <= 1'b1;
    end else if (wr_prot && req.dbg && state == SEQ_IDLE) begin
      prot <= req.wdata;
    end
  end

  // ****************************************************************
  // error and protection flags; a new event beats the clear
  // ****************************************************************
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ACC_ERR   <= 1'b0;
      PROT_VIOL <= 1'b0;
    end else begin
      if (err_event) begin
        ACC_ERR <= 1'b1;
      end else if (wr_stat && req.wdata[`FCP_ST_ACCER]) begin
        ACC_ERR <= 1'b0;
      end
      if (refuse) begin
        PROT_VIOL <= 1'b1;
      end else if (wr_stat && req.wdata[`FCP_ST_PVIOL]) begin
        PROT_VIOL <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // execution: buffer flag, busy countdown, array handshake
  // ****************************************************************
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      CBEF     <= 1'b1;
      BUSY     <= 1'b0;
      cnt      <= CNT_ZERO;
      FL_START <= 1'b0;
      FL_ABORT <= 1'b0;
      FL_CMD   <= `FCP_BYTE_ZERO;
      FL_ADDR  <= `FCP_ADDR_ZERO;
    end else begin
      FL_START <= 1'b0;
      FL_ABORT <= 1'b0;
      if (launch && !refuse) begin
        CBEF     <= 1'b0;
        BUSY     <= 1'b1;
        cnt      <= CNT_LOAD;
        FL_START <= 1'b1;
        FL_CMD   <= pend.code;
        FL_ADDR  <= pend.addr;
      end else if (stop_abort) begin
        CBEF     <= 1'b1;
        BUSY     <= 1'b0;
        cnt      <= CNT_ZERO;
        FL_ABORT <= 1'b1;
      end else if (BUSY) begin
        cnt <= cnt - CNT_ONE;
        if (done_event) begin
          CBEF <= 1'b1;
          BUSY <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // interrupt status, mask and output
  // ****************************************************************
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      irq_stat <= `FCP_IRQ_ZERO;
      irq_mask <= `FCP_IRQ_ZERO;
      IRQ      <= 1'b0;
    end else begin
      // set wins over a write-one clear in the same cycle
      irq_stat[`FCP_IRQ_ACCER] <= err_event || (irq_stat[`FCP_IRQ_ACCER]
        && !(req.wr && req.addr == `FCP_OFS_IRQ_STAT
             && req.wdata[`FCP_IRQ_ACCER]));
      irq_stat[`FCP_IRQ_PVIOL] <= refuse || (irq_stat[`FCP_IRQ_PVIOL]
        && !(req.wr && req.addr == `FCP_OFS_IRQ_STAT
             && req.wdata[`FCP_IRQ_PVIOL]));
      irq_stat[`FCP_IRQ_DONE] <= done_event || (irq_stat[`FCP_IRQ_DONE]
        && !(req.wr && req.addr == `FCP_OFS_IRQ_STAT
             && req.wdata[`FCP_IRQ_DONE]));
      if (req.wr && req.addr == `FCP_OFS_IRQ_MASK) begin
        irq_mask <= req.wdata[2:0];
      end
      IRQ <= |(irq_stat & irq_mask);
    end
  end

  // ****************************************************************
  // read data, one cycle after the strobe; unmapped reads zero
  // ****************************************************************
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      RDATA <= `FCP_BYTE_ZERO;
    end else if (req.rd) begin
      unique case (req.addr)
        `FCP_OFS_DIV:      RDATA <= {7'h00, div_written};
        `FCP_OFS_PROT:     RDATA <= prot;
        `FCP_OFS_STAT:     RDATA <= {CBEF, BUSY, PROT_VIOL, ACC_ERR, 4'h0};
        `FCP_OFS_CMD:      RDATA <= pend.code;
        `FCP_OFS_IRQ_STAT: RDATA <= {5'h00, irq_stat};
        `FCP_OFS_IRQ_MASK: RDATA <= {5'h00, irq_mask};
        default:           RDATA <= `FCP_BYTE_ZERO;
      endcase
    end else begin
      RDATA <= `FCP_BYTE_ZERO;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  // address, legal code, launch: three steps of a full entry
  sequence s_addr_taken;
    !ACC_ERR && ARRAY_WR && div_written && CBEF && state == SEQ_IDLE
      && !stop_abort;
  endsequence
  sequence s_code_taken;
    !ACC_ERR && wr_cmd && code_legal && !(req.dbg && SECURED)
      && !stop_abort;
  endsequence
  sequence s_launch;
    !ACC_ERR && !ARRAY_WR && wr_stat && req.wdata[`FCP_ST_CBEF]
      && !refuse && !stop_abort;
  endsequence

  a_full_launch: assert property (
    s_addr_taken ##1 s_code_taken ##1 s_launch |=> FL_START && !CBEF)
    else $error("complete entry did not start the command");
  a_flag_sticky: assert property (
    ACC_ERR && !(wr_stat && req.wdata[`FCP_ST_ACCER]) |=> ACC_ERR)
    else $error("access error flag dropped without a clear");
  a_div_first: assert property (
    ARRAY_WR && !ACC_ERR && !div_written |=> ACC_ERR && state == SEQ_IDLE)
    else $error("array write before divider set not flagged");
  a_busy_write: assert property (
    ARRAY_WR && !ACC_ERR && !CBEF |=> ACC_ERR)
    else $error("array write while buffer full not flagged");
  a_double_addr: assert property (
    s_addr_taken ##1 (ARRAY_WR && !stop_abort) |=> ACC_ERR)
    else $error("second array write not flagged");
  a_double_cmd: assert property (
    s_addr_taken ##1 s_code_taken ##1 (wr_cmd && !stop_abort) |=> ACC_ERR)
    else $error("second command write not flagged");
  a_bad_code: assert property (
    !ACC_ERR && wr_cmd && state == SEQ_ADDR && !code_legal
      |=> ACC_ERR ##1 state == SEQ_IDLE)
    else $error("illegal command code not flagged");
  a_secure_debug: assert property (
    !ACC_ERR && wr_cmd && req.dbg && SECURED
      && req.wdata == `FCP_CMD_PAGE |=> ACC_ERR)
    else $error("secured debug page erase not flagged");
  a_stop_abort: assert property (
    BUSY && STOP_ENTRY && FL_CMD != `FCP_CMD_BLANK
      |=> FL_ABORT && ACC_ERR && !BUSY)
    else $error("stop during program or erase not aborted");
  a_prot_refuse: assert property (
    launch && prot_on && pend.code == `FCP_CMD_PAGE && pend.addr > last_free
      |=> PROT_VIOL && !FL_START && !BUSY)
    else $error("protected erase was not refused");
  a_prot_locked: assert property (
    prot_loaded && !req.dbg |=> $stable(prot))
    else $error("protection register changed by software");

endmodule

// file: dv/fcp_array_model.sv
// far side model: flash array and its nonvolatile protection byte
// assumes the guard's launch and abort outputs on the same clock
`timescale 1ns/1ps
module fcp_array_model import fcp_pkg::*;
#(
  parameter logic [7:0] NV_BYTE = 8'hde  // top 8 KiB protected
) (
  input  wire logic        CLOCK,
  input  wire logic        RST,
  input  wire logic        FL_START,
  input  wire logic [7:0]  FL_CMD,
  input  wire logic [15:0] FL_ADDR,
  input  wire logic        FL_ABORT,
  output logic      [7:0]  NV_PROT_BYTE,
  output int               starts,
  output int               aborts,
  output fcp_cmd_t         last
);
  // ********
  // nonvolatile byte
  // ********
  // bit0 cleared so protection is on from the first edge
  assign NV_PROT_BYTE = NV_BYTE;
  // counts what reaches the array; the bench judges the totals
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      starts <= 0;
      aborts <= 0;
      last   <= '0;
    end else begin
      // launch: remember code and address
      if (FL_START) begin
        starts <= starts + 1;
        last   <= {FL_CMD, FL_ADDR};
      end
      // abort from stop entry
      if (FL_ABORT) begin
        aborts <= aborts + 1;
      end
    end
  end
endmodule

// file: dv/tb_fcp_flash_guard.sv
// self-checking bench for the flash command guard
// assumes fcp_pkg and the array model compiled before it
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
  num_errors++; $display("CHECK FAILED t=%0t got=%h exp=%h", \
  $time, (a), (b)); end end
module tb_fcp_flash_guard import fcp_pkg::*;;
  // ********
  // signals
  // ********
  logic        CLOCK, RST, WR, RD, DBG_ACCESS, ARRAY_WR;
  logic        SECURED, STOP_ENTRY, FL_START, FL_ABORT;
  logic        ACC_ERR, PROT_VIOL, CBEF, BUSY, IRQ;
  logic [2:0]  ADDR;
  logic [7:0]  WDATA, RDATA, FL_CMD, NV_PROT_BYTE, q;
  logic [15:0] ARRAY_ADDR, FL_ADDR;
  int          starts, aborts, n_start, num_errors, check_count;
  fcp_cmd_t    last;
  logic [7:0]  lc [5] = '{8'h05, 8'h20, 8'h25, 8'h40, 8'h41};
  logic [7:0]  sc [3] = '{8'h20, 8'h25, 8'h40};
  // short busy time keeps the run quick but leaves room for stop
  fcp_flash_guard #(.CMD_CYCLES(8)) dut (.CLOCK(CLOCK), .RST(RST),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .DBG_ACCESS(DBG_ACCESS), .RDATA(RDATA), .ARRAY_WR(ARRAY_WR),
    .ARRAY_ADDR(ARRAY_ADDR), .SECURED(SECURED),
    .STOP_ENTRY(STOP_ENTRY), .NV_PROT_BYTE(NV_PROT_BYTE),
    .FL_START(FL_START), .FL_CMD(FL_CMD), .FL_ADDR(FL_ADDR),
    .FL_ABORT(FL_ABORT), .ACC_ERR(ACC_ERR), .PROT_VIOL(PROT_VIOL),
    .CBEF(CBEF), .BUSY(BUSY), .IRQ(IRQ));
  fcp_array_model arr_m (.CLOCK(CLOCK), .RST(RST),
    .FL_START(FL_START), .FL_CMD(FL_CMD), .FL_ADDR(FL_ADDR),
    .FL_ABORT(FL_ABORT), .NV_PROT_BYTE(NV_PROT_BYTE),
    .starts(starts), .aborts(aborts), .last(last));
  initial begin
    CLOCK = 1'b0;
    forever #2 CLOCK = ~CLOCK;
  end
  // ********
  // access tasks: drive after an edge, release after the next
  // ********
  task automatic wr(input logic [2:0] a, input logic [7:0] d,
                    input logic g = 1'b0);
    @(posedge CLOCK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    DBG_ACCESS <= g;
    @(posedge CLOCK);
    WR <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge CLOCK);
    RD <= 1'b1;
    ADDR <= a;
    DBG_ACCESS <= 1'b0;
    @(posedge CLOCK);
    RD <= 1'b0;
    #1;
    d = RDATA;
  endtask
  task automatic arr(input logic [15:0] a);
    @(posedge CLOCK);
    ARRAY_WR <= 1'b1;
    ARRAY_ADDR <= a;
    @(posedge CLOCK);
    ARRAY_WR <= 1'b0;
  endtask
  task automatic summarize;
    $display("errors=%0d checks=%0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // bounded wait for an empty buffer and an idle array
  task automatic wait_idle;
    int n;
    n = 0;
    #1;
    while ((BUSY !== 1'b0 || CBEF !== 1'b1) && n < 100) begin
      @(posedge CLOCK);
      #1;
      n++;
    end
    if (n == 100) begin
      num_errors++;
      summarize();
    end
  endtask
  // error must be up now; clearing it with a one must drop it
  task automatic err;
    #1;
    `CHK(ACC_ERR, 1'b1)
    wr(3'h2, 8'h10);
    #1;
    `CHK(ACC_ERR, 1'b0)
  endtask
  task automatic launch(input logic [15:0] a, input logic [7:0] c);
    arr(a);
    wr(3'h3, c, SECURED);
    wr(3'h2, 8'h80, SECURED);
  endtask
  // full command; v set when protection must refuse it
  task automatic go(input logic [15:0] a, input logic [7:0] c,
                    input logic v);
    launch(a, c);
    #1;
    `CHK({BUSY, CBEF}, {~v, v})
    wait_idle();
    if (!v) n_start++;
    `CHK(starts, n_start)
    `CHK(PROT_VIOL, v)
    if (!v) `CHK(last, {c, a})
    if (v) wr(3'h2, 8'h20);
  endtask
  // address, optional code, optional second access, then error
  task automatic viol(input logic [7:0] c, input logic [2:0] a,
                      input logic [7:0] d, input logic r,
                      input logic g);
    arr(16'h1000);
    if (c != 8'h00) wr(3'h3, c, g);
    if (r) rd(a, q);
    else if (a != 3'h7) wr(a, d);
    err();
  endtask
  // ********
  // main sequence
  // ********
  initial begin
    {WR, RD, DBG_ACCESS, ARRAY_WR, SECURED, STOP_ENTRY} = '0;
    {ADDR, WDATA, ARRAY_ADDR} = '0;
    {n_start, num_errors, check_count} = '0;
    RST = 1'b1;
    repeat (8) @(posedge CLOCK);
    RST <= 1'b0;
    @(posedge CLOCK);
    rd(3'h1, q);
    `CHK(q, 8'hde)
    rd(3'h2, q);
    `CHK(q, 8'h80)
    rd(3'h6, q);
    `CHK(q, 8'h00)
    arr(16'h1000);
    err();
    wr(3'h0, 8'h01);
    rd(3'h0, q);
    `CHK(q, 8'h01)
    // second address write; commands are ignored until cleared
    arr(16'h1000);
    arr(16'h1000);
    launch(16'h1000, 8'h20);
    wait_idle();
    `CHK(starts, n_start)
    err();
    viol(8'h20, 3'h3, 8'h20, 1'b0, 1'b0);
    viol(8'h00, 3'h0, 8'h01, 1'b0, 1'b0);
    viol(8'h33, 3'h7, 8'h00, 1'b0, 1'b0);
    viol(8'h20, 3'h2, 8'h00, 1'b1, 1'b0);
    viol(8'h20, 3'h0, 8'h01, 1'b0, 1'b0);
    viol(8'h20, 3'h2, 8'h00, 1'b0, 1'b0);
    foreach (lc[i]) go(16'h1000, lc[i], lc[i] == 8'h41);
    go(16'hdfff, 8'h20, 1'b0);
    go(16'he000, 8'h40, 1'b1);
    go(16'hffff, 8'h05, 1'b0);
    // address write while the buffer is still full
    launch(16'h1000, 8'h20);
    arr(16'h1000);
    #1;
    `CHK(ACC_ERR, 1'b1)
    wait_idle();
    n_start++;
    err();
    // stop entry in mid-program aborts it
    launch(16'h1000, 8'h20);
    @(posedge CLOCK);
    STOP_ENTRY <= 1'b1;
    @(posedge CLOCK);
    STOP_ENTRY <= 1'b0;
    @(posedge CLOCK);
    n_start++;
    #1;
    `CHK(aborts, 1)
    `CHK({BUSY, CBEF}, 2'b01)
    err();
    @(posedge CLOCK);
    SECURED <= 1'b1;
    foreach (sc[i]) viol(sc[i], 3'h7, 8'h00, 1'b0, 1'b1);
    go(16'h1000, 8'h05, 1'b0);
    @(posedge CLOCK);
    SECURED <= 1'b0;
    wr(3'h1, 8'hff);
    rd(3'h1, q);
    `CHK(q, 8'hde)
    wr(3'h1, 8'hff, 1'b1);
    rd(3'h1, q);
    `CHK(q, 8'hff)
    go(16'he000, 8'h20, 1'b0);
    // errors, refusals and completions have all left sticky bits
    rd(3'h4, q);
    `CHK(q, 8'h07)
    // interrupt: unmasked error raises it, clearing status drops it
    wr(3'h4, 8'h07);
    wr(3'h5, 8'h01);
    viol(8'h33, 3'h7, 8'h00, 1'b0, 1'b0);
    rd(3'h4, q);
    `CHK(q, 8'h01)
    `CHK(IRQ, 1'b1)
    wr(3'h4, 8'h01);
    @(posedge CLOCK);
    #1;
    `CHK(IRQ, 1'b0)
    wr(3'h5, 8'h00);
    viol(8'h33, 3'h7, 8'h00, 1'b0, 1'b0);
    `CHK(IRQ, 1'b0)
    summarize();
  end
endmodule
